// File: hw/qtu_pkg.sv
// Constants, register map and carrier types of the quad timer unit.
// Assumes a Wishbone classic slave with the 8-bit registers in byte lane 0.
package qtu_pkg;
    localparam int ADR_W = 10;
    localparam int ADR_LSB = 2;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_EDGE = 8'hD4;
    localparam logic [7:0] IDX_T1 = 8'hF0;
    localparam logic [7:0] IDX_T2 = 8'hF1;
    localparam logic [7:0] IDX_T3 = 8'hF2;
    localparam logic [7:0] IDX_T4 = 8'hF3;
    localparam logic [7:0] IDX_FF = 8'hF7;
    localparam logic [7:0] IDX_PA = 8'hF8;
    localparam logic [7:0] IDX_PB = 8'hF9;
    localparam logic [7:0] IDX_EX = 8'hFA;
    localparam logic [7:0] IDX_SYS = 8'hFB;
    // Field positions
    localparam int PA_T1_STOP = 0;
    localparam int PA_T1_EV = 1;
    localparam int PA_T1_SUB = 2;
    localparam int PA_T1_OUT = 3;
    localparam int PA_T2_STOP = 4;
    localparam int PA_T2_OVF = 5;
    localparam int PA_T2_DIV = 6;
    localparam int PB_T3_STOP = 0;
    localparam int PB_T3_SRC = 1;
    localparam int PB_T4_STOP = 3;
    localparam int PB_T4_SRC = 4;
    localparam int PB_T4_PW = 6;
    localparam int PB_T4_OUT = 7;
    localparam int EX_PRE1 = 0;
    localparam int EX_PRE4 = 1;
    localparam int EX_T4_SUB = 5;
    localparam int EX_T2SEL = 6;
    localparam int EX_PWM = 7;
    localparam int SYS_SUB = 7;
    localparam int EP_POL0 = 2;
    localparam int EP_POL1 = 3;
    localparam int EP_PWSEL = 4;
    // Reset values
    localparam logic [7:0] PA_RST = 8'h11;
    localparam logic [7:0] PB_RST = 8'h09;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'hFF;
    // Source codes of timers 3 and 4
    localparam logic [1:0] T3_DIV16 = 2'h0;
    localparam logic [1:0] T3_SUB = 2'h1;
    localparam logic [1:0] T3_OVF = 2'h2;
    localparam logic [1:0] T3_EV = 2'h3;
    localparam logic [1:0] T4_T3OVF = 2'h0;
    localparam logic [1:0] T4_OSC = 2'h1;
    localparam logic [1:0] T4_OVF = 2'h2;
    localparam logic [1:0] T4_EV = 2'h3;
    // Prescaler masks and counter end values
    localparam logic [7:0] M16 = 8'h0F;
    localparam logic [7:0] M64 = 8'h3F;
    localparam logic [7:0] M128 = 8'h7F;
    localparam logic [7:0] M256 = 8'hFF;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    typedef struct packed {
        logic div16;
        logic div64;
        logic div128;
        logic div256;
        logic sub;
        logic ev0;
        logic ev1;
    } qtu_tick_t;
endpackage

// File: hw/qtu_top.sv
// Quad 8-bit timer unit with reload latches, pulse, width and PWM modes.
// Assumes pins synchronous to clk_i and a Wishbone classic master.
`timescale 1ns/1ps
module qtu_top
    import qtu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic first_counter_input_i,
    input wire logic second_counter_input_i,
    input wire logic main_oscillator_i,
    input wire logic sub_oscillator_i,
    input wire logic port1_pin2_dir_i,
    input wire logic port1_pin3_dir_i,
    output logic port1_pin2_o,
    output logic port1_pin2_oe_o,
    output logic port1_pin3_o,
    output logic port1_pin3_oe_o,
    output logic [3:0] timer_irq_o
);

    function automatic logic pick4(input logic [1:0] c, input logic [3:0] v);
        pick4 = v[c];
    endfunction

    function automatic logic div_hit(input logic [7:0] p, input logic [7:0] m);
        div_hit = ((p & m) == m);
    endfunction

    function automatic logic [7:0] cnt_step(input logic [7:0] c, input logic [7:0] l);
        cnt_step = (c == CNT_TOP) ? l - 8'h01 : c - 8'h01;
    endfunction

    logic [7:0] edge_reg, pair_a_reg, pair_b_reg, extra_reg, sys_reg;
    logic [7:0] cnt_reg [4];
    logic [7:0] latch_reg [4];
    logic out1_reg, out2_reg;
    logic [3:0] ovf_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] pre_reg;
    logic osc_prev_reg, sub_prev_reg, ev0_prev_reg, ev1_prev_reg;
    logic pin2_reg, pin2_oe_reg, pin3_reg, pin3_oe_reg;

    // ==========================================
    // Bus decode
    wire logic [7:0] idx = adr_i[ADR_W-1:ADR_LSB];
    wire logic req = cyc_i & stb_i;
    wire logic wr = req & we_i & sel_i[0] & ack_reg;
    wire logic [7:0] wd = dat_i[7:0];
    wire logic wr_edge = wr & (idx == IDX_EDGE);
    wire logic wr_pa = wr & (idx == IDX_PA);
    wire logic wr_pb = wr & (idx == IDX_PB);
    wire logic wr_ex = wr & (idx == IDX_EX);
    wire logic wr_sys = wr & (idx == IDX_SYS);
    wire logic wr_ff = wr & (idx == IDX_FF);
    wire logic [3:0] wr_t = {4{wr}} & {idx == IDX_T4, idx == IDX_T3,
                                       idx == IDX_T2, idx == IDX_T1};
    wire logic ack_next = req & ~ack_reg;
    logic [7:0] rd_next;

    // Timers read their live count
    always_comb
    begin
        rd_next = 8'h00;
        if (idx == IDX_EDGE) rd_next = edge_reg;
        else if (idx == IDX_T1) rd_next = cnt_reg[0];
        else if (idx == IDX_T2) rd_next = cnt_reg[1];
        else if (idx == IDX_T3) rd_next = cnt_reg[2];
        else if (idx == IDX_T4) rd_next = cnt_reg[3];
        else if (idx == IDX_FF) rd_next = {6'h00, out2_reg, out1_reg};
        else if (idx == IDX_PA) rd_next = pair_a_reg;
        else if (idx == IDX_PB) rd_next = pair_b_reg;
        else if (idx == IDX_EX) rd_next = extra_reg;
        else if (idx == IDX_SYS) rd_next = sys_reg;
    end

    // ==========================================
    // Count sources
    wire logic osc_sel = sys_reg[SYS_SUB] ? sub_oscillator_i : main_oscillator_i;
    wire logic osc_fall = osc_prev_reg & ~osc_sel;
    wire logic ev0_sig = first_counter_input_i ~^ edge_reg[EP_POL0];
    wire logic ev1_sig = second_counter_input_i ~^ edge_reg[EP_POL1];
    qtu_tick_t tk;
    assign tk.div16 = osc_fall & div_hit(pre_reg, M16);
    assign tk.div64 = osc_fall & div_hit(pre_reg, M64);
    assign tk.div128 = osc_fall & div_hit(pre_reg, M128);
    assign tk.div256 = osc_fall & div_hit(pre_reg, M256);
    assign tk.sub = sub_prev_reg & ~sub_oscillator_i;
    assign tk.ev0 = ev0_prev_reg & ~ev0_sig;
    assign tk.ev1 = ev1_prev_reg & ~ev1_sig;

    wire logic t2_chain = pair_a_reg[PA_T2_OVF];
    // Chained timer 2 forces the timer 1 overflow choice
    wire logic tovf = (t2_chain | ~extra_reg[EX_T2SEL]) ? ovf_reg[0] : ovf_reg[1];
    wire logic t4_osc = extra_reg[EX_T4_SUB] ? tk.sub : tk.div16;
    logic [3:0] tick;
    assign tick[0] = pair_a_reg[PA_T1_EV] ? tk.ev0 :
                     pair_a_reg[PA_T1_SUB] ? tk.sub : tk.div16;
    assign tick[1] = t2_chain ? ovf_reg[0] :
                     pick4(pair_a_reg[PA_T2_DIV+:2],
                           {tk.div256, tk.div128, tk.div64, tk.div16});
    assign tick[2] = pick4(pair_b_reg[PB_T3_SRC+:2],
                           {tk.ev1, tovf, tk.sub, tk.div16});
    assign tick[3] = pick4(pair_b_reg[PB_T4_SRC+:2],
                           {tk.ev1, tovf, t4_osc, ovf_reg[2]});

    // ==========================================
    // Run gating
    wire logic pwm = extra_reg[EX_PWM];
    wire logic pw_pin = edge_reg[EP_PWSEL] ? second_counter_input_i : first_counter_input_i;
    wire logic pw_lvl = edge_reg[EP_PWSEL] ? edge_reg[EP_POL1] : edge_reg[EP_POL0];
    wire logic pw_ok = (pw_pin == pw_lvl);
    logic [3:0] run;
    assign run[0] = ~pair_a_reg[PA_T1_STOP];
    assign run[1] = ~pair_a_reg[PA_T2_STOP];
    assign run[2] = ~pair_b_reg[PB_T3_STOP] & ~(pwm & out2_reg);
    assign run[3] = pwm ? (~pair_b_reg[PB_T4_STOP] & out2_reg) :
                    pair_b_reg[PB_T4_PW] ? pw_ok : ~pair_b_reg[PB_T4_STOP];
    wire logic [3:0] step = tick & run;
    // PWM keeps the counter of a running timer 3 or 4 on writes
    wire logic [3:0] keep = {pwm & run[3], pwm & run[2], 2'b00};
    wire logic [3:0] wr_load = wr_t & ~keep;

    // ==========================================
    // Registers and bus answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            edge_reg <= REG_RST;
            pair_a_reg <= PA_RST;
            pair_b_reg <= PB_RST;
            extra_reg <= REG_RST;
            sys_reg <= REG_RST;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else
        begin
            if (wr_edge) edge_reg <= wd;
            if (wr_pa) pair_a_reg <= wd;
            if (wr_pb) pair_b_reg <= wd;
            if (wr_ex) extra_reg <= wd;
            if (wr_sys) sys_reg <= wd;
            ack_reg <= ack_next;
            if (ack_next) dat_reg <= {24'h00_0000, rd_next};
        end
    end

    // ==========================================
    // Prescaler and edge history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_reg <= 8'h00;
            osc_prev_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
            ev0_prev_reg <= 1'b0;
            ev1_prev_reg <= 1'b0;
        end
        else
        begin
            if (osc_fall) pre_reg <= pre_reg + 8'h01;
            osc_prev_reg <= osc_sel;
            sub_prev_reg <= sub_oscillator_i;
            ev0_prev_reg <= ev0_sig;
            ev1_prev_reg <= ev1_sig;
        end
    end

    // ==========================================
    // Counters
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (rst_i)
            begin
                cnt_reg[i] <= CNT_RST;
                latch_reg[i] <= CNT_RST;
                ovf_reg[i] <= 1'b0;
            end
            else
            begin
                if (wr_t[i]) latch_reg[i] <= wd;
                if (wr_load[i]) cnt_reg[i] <= wd;
                else if (step[i])
                    cnt_reg[i] <= cnt_step(cnt_reg[i], latch_reg[i]);
                ovf_reg[i] <= step[i] & (cnt_reg[i] == CNT_ZERO);
            end
        end
    end

    // ==========================================
    // Output flip-flops and pins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out1_reg <= 1'b0;
            out2_reg <= 1'b0;
            pin2_reg <= 1'b0;
            pin2_oe_reg <= 1'b0;
            pin3_reg <= 1'b0;
            pin3_oe_reg <= 1'b0;
        end
        else
        begin
            if (wr_ff & extra_reg[EX_PRE1]) out1_reg <= wd[0];
            else if (ovf_reg[0]) out1_reg <= ~out1_reg;
            if (wr_ff & extra_reg[EX_PRE4]) out2_reg <= wd[1];
            else if (pwm & ovf_reg[2]) out2_reg <= 1'b1;
            else if (pwm & ovf_reg[3]) out2_reg <= 1'b0;
            else if (~pwm & ovf_reg[3]) out2_reg <= ~out2_reg;
            pin2_reg <= out1_reg;
            pin2_oe_reg <= pair_a_reg[PA_T1_OUT] & port1_pin2_dir_i;
            pin3_reg <= out2_reg;
            pin3_oe_reg <= pair_b_reg[PB_T4_OUT] & port1_pin3_dir_i;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign port1_pin2_o = pin2_reg;
    assign port1_pin2_oe_o = pin2_oe_reg;
    assign port1_pin3_o = pin3_reg;
    assign port1_pin3_oe_o = pin3_oe_reg;
    assign timer_irq_o = ovf_reg;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_t1_stop_hold: assert property (pair_a_reg[PA_T1_STOP] && !wr_t[0]
        |=> $stable(cnt_reg[0]))
        else $error("timer 1 moved while stopped");
    a_t2_stop_hold: assert property (pair_a_reg[PA_T2_STOP] && !wr_t[1]
        |=> $stable(cnt_reg[1]))
        else $error("timer 2 moved while stopped");
    a_t1_wrap_ovf: assert property (step[0] && cnt_reg[0] == 8'h00 && !wr_t[0]
        |=> (ovf_reg[0] && cnt_reg[0] == 8'hFF) ##1 (!ovf_reg[0] || wr_t[0]))
        else $error("timer 1 wrap without overflow");
    a_t1_reload: assert property (step[0] && cnt_reg[0] == 8'hFF && !wr_t[0]
        |=> cnt_reg[0] == $past(latch_reg[0]) - 8'h01)
        else $error("timer 1 reload wrong");
    a_t3_forced_src: assert property (t2_chain
        && pair_b_reg[PB_T3_SRC+:2] == T3_OVF |-> tick[2] == ovf_reg[0])
        else $error("timer 3 not fed by timer 1 overflow");
    a_out1_toggle: assert property (ovf_reg[0] && !(wr_ff && extra_reg[EX_PRE1])
        |=> out1_reg != $past(out1_reg) ##1 port1_pin2_o == $past(out1_reg))
        else $error("first output not toggled");
    a_pin2_enable: assert property (pair_a_reg[PA_T1_OUT] && port1_pin2_dir_i
        |=> port1_pin2_oe_o)
        else $error("pin 1.2 not driven");
    a_pwm_rise: assert property (pwm && ovf_reg[2]
        && !(wr_ff && extra_reg[EX_PRE4]) |=> out2_reg && !run[2])
        else $error("pwm high phase not entered");
    a_pwm_latch_only: assert property (pwm && wr_t[3] && run[3] && !step[3]
        |=> $stable(cnt_reg[3]))
        else $error("running pwm timer counter overwritten");
    a_pw_gate: assert property (!pwm && pair_b_reg[PB_T4_PW] && !pw_ok && !wr_t[3]
        |=> $stable(cnt_reg[3]))
        else $error("pulse width counted at wrong level");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");

endmodule

// File: tb/qtu_pins_model.sv
// Far-side model: counter input pins and both oscillators.
// Assumes a request strobe per line, one clk long, from the bench.
`timescale 1ns/1ps
module qtu_pins_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] base_lvl_i,
    input wire logic [3:0] pulse_req_i,
    output logic [3:0] line_o
);
    // ==========================================
    // Pulse stretch
    logic [2:0] hold_reg [4];
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (rst_i)
                hold_reg[i] <= 3'h0;
            else if (pulse_req_i[i])
                hold_reg[i] <= 3'h4;
            else if (hold_reg[i] != 3'h0)
                hold_reg[i] <= hold_reg[i] - 3'h1;
        end
    end
    // One inverted excursion gives exactly one falling edge of the effective level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            line_o[i] = base_lvl_i[i] ^ (hold_reg[i] != 3'h0);
    end
endmodule

// File: tb/qtu_top_tb_top.sv
// Self-checking bench of the quad timer unit over Wishbone classic.
// Assumes the pins model supplies event and oscillator lines.
`timescale 1ns/1ps
module qtu_top_tb_top
    import qtu_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, p12, p12_oe, p13, p13_oe;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] dat_w = '0, dat_r;
    logic [3:0] lvl = 4'hC, preq = 4'h0, line, irq;
    logic [1:0] dir = 2'h0;
    int irq_cnt [4];
    int failures = 0, n_compared = 0, cycles = 0;

    qtu_pins_model qtu_pins_model_inst (.clk_i(clk_i), .rst_i(rst_i), .base_lvl_i(lvl),
        .pulse_req_i(preq), .line_o(line));
    qtu_top qtu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .first_counter_input_i(line[0]), .second_counter_input_i(line[1]),
        .main_oscillator_i(line[2]), .sub_oscillator_i(line[3]),
        .port1_pin2_dir_i(dir[0]), .port1_pin3_dir_i(dir[1]), .port1_pin2_o(p12),
        .port1_pin2_oe_o(p12_oe), .port1_pin3_o(p13), .port1_pin3_oe_o(p13_oe),
        .timer_irq_o(irq));

    // ==========================================
    // Clock, overflow tally, timeout
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        for (int i = 0; i < 4; i++)
            irq_cnt[i] = rst_i ? 0 : irq_cnt[i] + int'(irq[i] === 1'b1);
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ==========================================
    // Tasks
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {24'h000000, wd};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, idx, d, x);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        wb(1'b0, idx, 8'h00, x);
        check(name, x, exp);
    endtask
    task automatic pulse(input int ln, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            preq[ln] <= 1'b1;
            @(posedge clk_i);
            preq[ln] <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("pair a", IDX_PA, 8'h11);
        rd_chk("pair b", IDX_PB, 8'h09);
        rd_chk("timer1", IDX_T1, 8'hFF);
        rd_chk("extra", IDX_EX, 8'h00);
        wr(8'h01, 8'h5A);
        rd_chk("unmapped", 8'h01, 8'h00);
        // Timer 1 counts inverted first input, timer 2 chained, pulse output on pin 1.2
        wr(IDX_T1, 8'h02);
        wr(IDX_T2, 8'h05);
        wr(IDX_PA, 8'h2A);
        repeat (2) @(posedge clk_i);
        check("oe2 dir in", {7'h00, p12_oe}, 8'h00);
        dir <= 2'h3;
        pulse(0, 1);
        rd_chk("t1 first", IDX_T1, 8'h01);
        check("oe2", {7'h00, p12_oe}, 8'h01);
        pulse(0, 2);
        rd_chk("t1 wrap", IDX_T1, 8'hFF);
        check("irq1", 8'(irq_cnt[0]), 8'h01);
        rd_chk("t2 chained", IDX_T2, 8'h04);
        check("pin2 toggled", {7'h00, p12}, 8'h01);
        pulse(0, 1);
        rd_chk("t1 reload", IDX_T1, 8'h01);
        // Preset of the first output level, then reload and restart
        wr(IDX_PA, 8'h2B);
        wr(IDX_EX, 8'h01);
        wr(IDX_FF, 8'h00);
        wr(IDX_T1, 8'h02);
        wr(IDX_PA, 8'h2A);
        check("pin2 preset", {7'h00, p12}, 8'h00);
        rd_chk("preset flops", IDX_FF, 8'h00);
        wr(IDX_EX, 8'h00);
        // PWM pair on pin 1.3 from the sub oscillator
        wr(IDX_T3, 8'h01);
        wr(IDX_T4, 8'h02);
        wr(IDX_EX, 8'hA0);
        wr(IDX_PB, 8'h92);
        pulse(3, 2);
        check("pwm high", {7'h00, p13}, 8'h01);
        check("oe3", {7'h00, p13_oe}, 8'h01);
        rd_chk("t4 idle", IDX_T4, 8'h02);
        wr(IDX_T4, 8'h06);
        rd_chk("t4 running latch only", IDX_T4, 8'h02);
        pulse(3, 3);
        check("pwm low", {7'h00, p13}, 8'h00);
        check("irq3", 8'(irq_cnt[2]), 8'h01);
        check("irq4", 8'(irq_cnt[3]), 8'h01);
        rd_chk("t3 held", IDX_T3, 8'hFF);
        wr(IDX_T3, 8'h05);
        rd_chk("t3 latch only", IDX_T3, 8'hFF);
        wr(IDX_T4, 8'h07);
        rd_chk("t4 idle load", IDX_T4, 8'h07);
        pulse(3, 1);
        rd_chk("t3 new latch", IDX_T3, 8'h04);
        // Timer 4 counts inverted second input, pulse output on pin 1.3
        wr(IDX_EX, 8'h00);
        wr(IDX_PB, 8'hB1);
        wr(IDX_T4, 8'h01);
        pulse(1, 2);
        check("pin3 toggled", {7'h00, p13}, 8'h01);
        check("irq4 event", 8'(irq_cnt[3]), 8'h02);
        rd_chk("t4 event wrap", IDX_T4, 8'hFF);
        pulse(1, 2);
        check("pin3 back", {7'h00, p13}, 8'h00);
        check("irq4 divide", 8'(irq_cnt[3]), 8'h03);
        // Timer 4 measures the high time of the second input on the sub oscillator
        wr(IDX_PB, 8'hD1);
        wr(IDX_EX, 8'h20);
        wr(IDX_EDGE, 8'h18);
        wr(IDX_T4, 8'h09);
        pulse(3, 2);
        rd_chk("pw input low", IDX_T4, 8'h09);
        lvl <= 4'hE;
        pulse(3, 2);
        rd_chk("pw input high", IDX_T4, 8'h07);
        // Timer 3 on timer overflow with timer 2 chained takes timer 1 overflow
        wr(IDX_T3, 8'h03);
        wr(IDX_PB, 8'h0C);
        wr(IDX_EX, 8'h40);
        pulse(0, 3);
        rd_chk("t3 forced src", IDX_T3, 8'h02);
        rd_chk("t3 ovf src t2", IDX_T2, 8'h03);
        check("irq1 again", 8'(irq_cnt[0]), 8'h02);
        check("pin2 again", {7'h00, p12}, 8'h01);
        // Timer 1 on the main oscillator divided by 16
        wr(IDX_PA, 8'h28);
        wr(IDX_T1, 8'h05);
        pulse(2, 15);
        rd_chk("t1 osc 15 falls", IDX_T1, 8'h05);
        pulse(2, 1);
        rd_chk("t1 osc 16 falls", IDX_T1, 8'h04);
        tally_and_finish();
    end
endmodule
